/* rtl/i2csas_defines.vh */
// Constants for the two-wire slave with strapped address select
`ifndef I2CSAS_DEFINES_VH
`define I2CSAS_DEFINES_VH
// ****************************************
// Addresses
// ****************************************
`define I2CSAS_BASE_ADDR 7'h50
`define I2CSAS_BCAST_ADDR 7'h58
// ****************************************
// Strap thresholds in kilohms, between neighbouring nominals
// ****************************************
`define I2CSAS_THR0 8'h12
`define I2CSAS_THR1 8'h24
`define I2CSAS_THR2 8'h36
`define I2CSAS_THR3 8'h48
`define I2CSAS_THR4 8'h5A
`define I2CSAS_THR5 8'h6B
`define I2CSAS_THR6 8'h7D
`define I2CSAS_WARN_BAND 8'h04
// ****************************************
// Timing
// ****************************************
`define I2CSAS_CLK_MHZ 125
`define I2CSAS_TLOW_MIN_US 650
`define I2CSAS_TLOW_MIN_CYC (`I2CSAS_TLOW_MIN_US * `I2CSAS_CLK_MHZ)
`endif

/* rtl/i2csas_strap_decode.v */
// Strap value to address index decode with near-threshold warning
`timescale 1ns/1ps
`default_nettype none
`include "i2csas_defines.vh"
module i2csas_strap_decode
(
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Measured strap
    input wire [7:0] strapKohm,
    input wire strapValid,
    // Result
    output reg [2:0] addrIdx_q,
    output reg warn_q,
    output reg done_q
);
    // ****************************************
    // Helpers
    // ****************************************
    // Distance of the strap to one threshold is under the warning band
    function near;
        input [7:0] v;
        input [7:0] t;
        begin
            near = (v >= t) ? ((v - t) < `I2CSAS_WARN_BAND) : ((t - v) < `I2CSAS_WARN_BAND);
        end
    endfunction

    // Counts one per threshold at or below the strap
    function [2:0] idx;
        input [7:0] v;
        begin
            idx = {2'h0, v >= `I2CSAS_THR0} + {2'h0, v >= `I2CSAS_THR1} + {2'h0, v >= `I2CSAS_THR2}
                + {2'h0, v >= `I2CSAS_THR3} + {2'h0, v >= `I2CSAS_THR4} + {2'h0, v >= `I2CSAS_THR5}
                + {2'h0, v >= `I2CSAS_THR6};
        end
    endfunction

    // ****************************************
    // One-shot capture
    // ****************************************
    // Captured once, later strap readings are ignored so the address never moves
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addrIdx_q <= 3'h0;
            warn_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (strapValid && !done_q)
        begin
            addrIdx_q <= idx(strapKohm); // [RL2] [RL3] [RL4]
            warn_q <= near(strapKohm, `I2CSAS_THR0) | near(strapKohm, `I2CSAS_THR1)
                | near(strapKohm, `I2CSAS_THR2) | near(strapKohm, `I2CSAS_THR3)
                | near(strapKohm, `I2CSAS_THR4) | near(strapKohm, `I2CSAS_THR5)
                | near(strapKohm, `I2CSAS_THR6); // [RL5]
            done_q <= 1'b1; // [RL12]
        end
    end
endmodule // i2csas_strap_decode
`default_nettype wire

/* rtl/i2csas_top.v */
// Two-wire serial slave with strapped address select and broadcast write
`timescale 1ns/1ps
`default_nettype none
`include "i2csas_defines.vh"
// Behaviour
// [RL1] Slave only; master starts and clocks everything
// [RL2] Address from strap: one of 0x50..0x57
// [RL3] Ground 0x50, supply 0x57, ascending between
// [RL4] Plus or minus 2 kilohms keeps address
// [RL5] Near-threshold strap raises address warning flag
// [RL6] Broadcast address 0x58 also accepted
// [RL7] Broadcast serves writes only, never drive reads
// [RL8] Data low too long resets interface
// [RL9] Address, direction bit, ninth-clock acknowledge
// [RL10] First write byte is pointer, data follows
// [RL11] Master ends read with no-ack, stop
// [RL12] Resolve address once, silent until resolved
module i2csas_top
#(
    parameter TIMEOUT_CYC = `I2CSAS_TLOW_MIN_CYC
)
(
    // Clock and reset
    input wire sys_clk,
    input wire arst_n,
    // Bus pins
    input wire sclIn,
    input wire sdaIn,
    output reg sdaOut_q,
    output reg sdaOe_n_q,
    // Strap measurement
    input wire [7:0] strapKohm,
    input wire strapValid,
    // Register side
    output reg wrValid_q,
    output reg [7:0] wrPtr_q,
    output reg [7:0] wrData_q,
    output reg [7:0] rdPtr_q,
    input wire [7:0] rdData,
    output reg rdTake_q,
    // Status
    output reg addrWarn_q,
    output reg addrReady_q,
    output reg [6:0] slaveAddr_q
);
    // ****************************************
    // States
    // ****************************************
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_ADDR = 7'h02;
    localparam [6:0] ST_ACKA = 7'h04;
    localparam [6:0] ST_WR = 7'h08;
    localparam [6:0] ST_ACKW = 7'h10;
    localparam [6:0] ST_RD = 7'h20;
    localparam [6:0] ST_ACKR = 7'h40;

    reg rstMeta;
    reg rst_n_q;
    reg sclMeta;
    reg sclSync;
    reg sclOld;
    reg sdaMeta;
    reg sdaSync;
    reg sdaOld;
    reg [6:0] state_q;
    reg [3:0] bitCnt_q;
    reg [7:0] shift_q;
    reg isRead_q;
    reg havePtr_q;
    reg [7:0] ptr_q;
    reg [17:0] lowCnt_q;
    wire [2:0] addrIdx;
    wire warn;
    wire done;
    wire sclRise = sclSync & ~sclOld;
    wire sclFall = ~sclSync & sclOld;
    wire startCond = sclSync & sclOld & sdaOld & ~sdaSync;
    wire stopCond = sclSync & sclOld & ~sdaOld & sdaSync;
    wire timeout = (lowCnt_q == TIMEOUT_CYC[17:0]);
    wire byteDone = (bitCnt_q == 4'h8);
    wire ownHit = addrReady_q && (shift_q[7:1] == slaveAddr_q); // [RL12]
    wire bcastHit = addrReady_q && (shift_q[7:1] == `I2CSAS_BCAST_ADDR) && !shift_q[0]; // [RL6] [RL7]

    // ****************************************
    // Reset release
    // ****************************************
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rstMeta <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rst_n_q <= rstMeta;
        end
    end

    // ****************************************
    // Pin synchronisers and edge history
    // ****************************************
    // Idle bus is high, so history resets high to avoid a false start
    always @(posedge sys_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            sclMeta <= 1'b1;
            sclSync <= 1'b1;
            sclOld <= 1'b1;
            sdaMeta <= 1'b1;
            sdaSync <= 1'b1;
            sdaOld <= 1'b1;
        end
        else
        begin
            sclMeta <= sclIn;
            sclSync <= sclMeta;
            sclOld <= sclSync;
            sdaMeta <= sdaIn;
            sdaSync <= sdaMeta;
            sdaOld <= sdaSync;
        end
    end

    // ****************************************
    // Strap decode
    // ****************************************
    i2csas_strap_decode u_strap
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n_q),
        .strapKohm(strapKohm),
        .strapValid(strapValid),
        .addrIdx_q(addrIdx),
        .warn_q(warn),
        .done_q(done)
    );

    // Held after the one-shot capture; status flag mirrors the warning
    always @(posedge sys_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            slaveAddr_q <= `I2CSAS_BASE_ADDR;
            addrWarn_q <= 1'b0;
            addrReady_q <= 1'b0;
        end
        else
        begin
            slaveAddr_q <= `I2CSAS_BASE_ADDR + {4'h0, addrIdx}; // [RL2]
            addrWarn_q <= warn; // [RL5]
            addrReady_q <= done; // [RL12]
        end
    end

    // ****************************************
    // Stuck data line watchdog
    // ****************************************
    // Least time rounded up; stays well under the longest allowed time
    always @(posedge sys_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            lowCnt_q <= 18'h00000;
        else if (sdaSync || timeout)
            lowCnt_q <= 18'h00000;
        else
            lowCnt_q <= lowCnt_q + 18'h00001; // [RL8]
    end

    // ****************************************
    // Protocol engine
    // ****************************************
    // Everything moves on bus edges or the data-low timeout only; this end never drives the clock
    always @(posedge sys_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= ST_IDLE;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            isRead_q <= 1'b0;
            havePtr_q <= 1'b0;
            ptr_q <= 8'h00;
            sdaOut_q <= 1'b0;
            sdaOe_n_q <= 1'b1;
            wrValid_q <= 1'b0;
            wrPtr_q <= 8'h00;
            wrData_q <= 8'h00;
            rdPtr_q <= 8'h00;
            rdTake_q <= 1'b0;
        end
        else
        begin
            wrValid_q <= 1'b0;
            rdTake_q <= 1'b0;
            sdaOut_q <= 1'b0;
            rdPtr_q <= ptr_q;
            if (timeout || stopCond)
            begin
                state_q <= ST_IDLE; // [RL8] [RL11]
                sdaOe_n_q <= 1'b1;
            end
            else if (startCond)
            begin
                state_q <= ST_ADDR; // [RL1] [RL9]
                bitCnt_q <= 4'h0;
                havePtr_q <= 1'b0;
                sdaOe_n_q <= 1'b1;
            end
            else
            begin
                case (state_q)
                    ST_IDLE:
                        sdaOe_n_q <= 1'b1;
                    ST_ADDR, ST_WR:
                    begin
                        if (sclRise && !byteDone)
                        begin
                            shift_q <= {shift_q[6:0], sdaSync}; // [RL9]
                            bitCnt_q <= bitCnt_q + 4'h1;
                        end
                        else if (sclFall && byteDone)
                        begin
                            bitCnt_q <= 4'h0;
                            if (state_q == ST_ADDR && (ownHit || bcastHit))
                            begin
                                isRead_q <= shift_q[0];
                                sdaOe_n_q <= 1'b0; // [RL9]
                                state_q <= ST_ACKA;
                            end
                            else if (state_q == ST_ADDR)
                                state_q <= ST_IDLE;
                            else
                            begin
                                if (!havePtr_q)
                                begin
                                    ptr_q <= shift_q; // [RL10]
                                    havePtr_q <= 1'b1;
                                end
                                else
                                begin
                                    wrValid_q <= 1'b1; // [RL10]
                                    wrPtr_q <= ptr_q;
                                    wrData_q <= shift_q;
                                    ptr_q <= ptr_q + 8'h01;
                                end
                                sdaOe_n_q <= 1'b0;
                                state_q <= ST_ACKW;
                            end
                        end
                    end
                    ST_ACKA, ST_ACKW, ST_ACKR:
                    begin
                        // Master no-ack ends a read; one shared load serves address ack and master ack
                        if (sclRise && state_q == ST_ACKR)
                            isRead_q <= ~sdaSync; // [RL11]
                        else if (sclFall)
                        begin
                            if (state_q != ST_ACKW && isRead_q)
                            begin
                                shift_q <= {rdData[6:0], 1'b0};
                                rdTake_q <= 1'b1;
                                sdaOe_n_q <= rdData[7];
                                bitCnt_q <= 4'h1;
                                ptr_q <= ptr_q + 8'h01;
                                state_q <= ST_RD;
                            end
                            else if (state_q == ST_ACKR)
                                state_q <= ST_IDLE;
                            else
                            begin
                                sdaOe_n_q <= 1'b1;
                                state_q <= ST_WR;
                            end
                        end
                    end
                    ST_RD:
                    begin
                        if (sclFall && byteDone)
                        begin
                            sdaOe_n_q <= 1'b1;
                            state_q <= ST_ACKR;
                        end
                        else if (sclFall)
                        begin
                            sdaOe_n_q <= shift_q[7];
                            shift_q <= {shift_q[6:0], 1'b0};
                            bitCnt_q <= bitCnt_q + 4'h1;
                        end
                    end
                    default:
                        state_q <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // i2csas_top
`default_nettype wire

/* bench/i2csas_chk.sv */
// Port checks for the strapped-address two-wire slave
`timescale 1ns/1ps
`default_nettype none
module i2csas_chk
#(
    parameter int TIMEOUT_CYC = 200
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Bus side
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut_q,
    input wire logic sdaOe_n_q,
    // Strobes and status
    input wire logic wrValid_q,
    input wire logic rdTake_q,
    input wire logic addrReady_q,
    input wire logic [6:0] slaveAddr_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Data-low run length; saturates so a stuck line never wraps it
    int lowCnt_q;
    always_ff @(posedge sys_clk or negedge arst_n)
        if (!arst_n)
            lowCnt_q <= 0;
        else if (sdaIn)
            lowCnt_q <= 0;
        else if (lowCnt_q < TIMEOUT_CYC + 8)
            lowCnt_q <= lowCnt_q + 1;
    // Open drain only ever pulls low
    drive_zero_a: assert property (sdaOut_q == 1'b0) else $error("drive value high");
    addr_range_a: assert property (addrReady_q |-> slaveAddr_q inside {[7'h50:7'h57]})
        else $error("address out of range");
    silent_unready_a: assert property (!addrReady_q |-> sdaOe_n_q)
        else $error("drive before ready");
    addr_hold_a: assert property (addrReady_q && $past(addrReady_q) |-> $stable(slaveAddr_q))
        else $error("address changed");
    wr_pulse_a: assert property (wrValid_q |=> !wrValid_q) else $error("write strobe long");
    rd_pulse_a: assert property (rdTake_q |=> !rdTake_q) else $error("read strobe long");
    oe_scl_low_a: assert property ($changed(sdaOe_n_q) |-> !sclIn)
        else $error("data moved in clock high");
    timeout_release_a: assert property (lowCnt_q == TIMEOUT_CYC + 8 |-> sdaOe_n_q)
        else $error("line held past timeout");
endmodule // i2csas_chk
bind i2csas_top i2csas_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) i2csas_chk_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut_q(sdaOut_q), .sdaOe_n_q(sdaOe_n_q), .wrValid_q(wrValid_q),
    .rdTake_q(rdTake_q), .addrReady_q(addrReady_q), .slaveAddr_q(slaveAddr_q));
`default_nettype wire

/* bench/i2csas_master.sv */
// Bus master model: clocks the bus and pulls the data line low
`timescale 1ns/1ps
`default_nettype none
module i2csas_master
(
    // Clock line and data release flag
    output logic scl = 1'b1,
    output logic sdaRel = 1'b1,
    // Resolved data wire
    input wire logic sdaLine
);
    localparam realtime Q = 31.25; // Quarter of a 125 ns bit
    // Start or repeated start; clock left low
    task automatic start();
        // Let a slave ack end before the clock rises, else a stray stop
        #Q sdaRel = 1'b1;
        #Q scl = 1'b1;
        #Q sdaRel = 1'b0;
        #Q scl = 1'b0;
    endtask
    // One bit: data set while clock low, sampled mid-high
    task automatic bitX(input logic d, output logic s);
        #Q sdaRel = d;
        #Q scl = 1'b1;
        #Q s = sdaLine;
        #Q scl = 1'b0;
    endtask
    // Byte out, MSB first, then slave acknowledge
    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bitX(d[i], s);
        bitX(1'b1, s);
        ack = !s;
    endtask
    // Byte in; a missing acknowledge marks the last one
    task automatic recvByte(input logic mAck, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bitX(1'b1, d[i]);
        bitX(!mAck, s);
    endtask
    // Stop: data rises while clock high
    task automatic stop();
        #Q sdaRel = 1'b0;
        #Q scl = 1'b1;
        #Q sdaRel = 1'b1;
        #Q;
    endtask
endmodule // i2csas_master
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the strapped-address two-wire slave
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int TMO = 400;
    // Strap kilohms above, then warn bit and address
    localparam logic [15:0] ROWS [15] = '{16'h0050, 16'h0950, 16'h0B50, 16'h10D0, 16'h14D1, 16'h1951,
        16'h2D52, 16'h3F53, 16'h5154, 16'h6455, 16'h6DD6, 16'h7456, 16'h7BD6, 16'h8657, 16'hFF57};
    // Design pins
    logic sys_clk;
    logic arst_n = 1'b0;
    logic strapValid = 1'b0;
    logic [7:0] strapKohm = 8'h00;
    wire scl, sdaRel, sdaOut_q, sdaOe_n_q, wrValid_q, rdTake_q, addrWarn_q, addrReady_q;
    wire [7:0] wrPtr_q, wrData_q, rdPtr_q;
    wire [6:0] slaveAddr_q;
    // Pulled-up data wire; registers outside read as pointer plus 0x30
    wire sdaLine = sdaRel & (sdaOe_n_q | sdaOut_q);
    wire [7:0] rdData = rdPtr_q + 8'h30;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;
    logic ak, drv;
    logic [15:0] takes = 16'h0000;
    logic [7:0] b;
    logic [15:0] wrLog [$];
    i2csas_top #(.TIMEOUT_CYC(TMO)) i2csas_top_i (.sys_clk(sys_clk), .arst_n(arst_n), .sclIn(scl),
        .sdaIn(sdaLine), .sdaOut_q(sdaOut_q), .sdaOe_n_q(sdaOe_n_q), .strapKohm(strapKohm),
        .strapValid(strapValid), .wrValid_q(wrValid_q), .wrPtr_q(wrPtr_q), .wrData_q(wrData_q),
        .rdPtr_q(rdPtr_q), .rdData(rdData), .rdTake_q(rdTake_q), .addrWarn_q(addrWarn_q),
        .addrReady_q(addrReady_q), .slaveAddr_q(slaveAddr_q));
    i2csas_master mst (.scl(scl), .sdaRel(sdaRel), .sdaLine(sdaLine));
    // 125 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Log writes, note any drive, cut a hang short
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (wrValid_q === 1'b1)
            wrLog.push_back({wrPtr_q, wrData_q});
        if (sdaOe_n_q === 1'b0)
            drv = 1'b1;
        if (rdTake_q === 1'b1)
            takes = takes + 16'h0001;
        if (cyc == 60000)
        begin
            err_count++;
            summarize();
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d errors=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Reset held 8 cycles; strap only after the synchroniser settles
    task automatic rst();
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic strap(input logic [7:0] k);
        strapKohm <= k;
        strapValid <= 1'b1;
        @(posedge sys_clk);
        strapValid <= 1'b0;
        for (int n = 0; n < 20 && addrReady_q !== 1'b1; n++) @(posedge sys_clk);
    endtask
    // Write: pointer byte, then n bytes counting up from d
    task automatic xfer(input logic [6:0] a, input logic [7:0] p, input int n, input logic [7:0] d);
        mst.start();
        mst.sendByte({a, 1'b0}, ak);
        if (ak)
        begin
            mst.sendByte(p, ak);
            for (int i = 0; i < n; i++)
                mst.sendByte(d + 8'(i), ak);
        end
        mst.stop();
    endtask
    // Main sequence
    initial
    begin
        foreach (ROWS[i])
        begin
            rst();
            strap(ROWS[i][15:8]);
            chk({addrWarn_q, slaveAddr_q}, ROWS[i][7:0]);
            wrLog.delete();
            xfer(ROWS[i][6:0], 8'h10, 1, 8'hC3);
            chk({ak, 15'(wrLog.size())}, 16'h8001);
            chk(wrLog[0], 16'h10C3);
            $display("strap row %0d done", i);
        end
        rst();
        chk(addrReady_q, 1'b0);
        xfer(7'h50, 8'h00, 0, 8'h00);
        chk(ak, 1'b0);
        strap(8'h3F);
        chk(addrReady_q, 1'b1);
        wrLog.delete();
        xfer(7'h54, 8'h01, 1, 8'h55);
        chk(ak, 1'b0);
        xfer(7'h58, 8'h20, 2, 8'hA1);
        chk({ak, 15'(wrLog.size())}, 16'h8002);
        chk(wrLog[0], 16'h20A1);
        chk(wrLog[1], 16'h21A2);
        drv = 1'b0;
        mst.start();
        mst.sendByte({7'h58, 1'b1}, ak);
        mst.recvByte(1'b0, b);
        mst.stop();
        chk({ak, b, drv}, 16'h01FE);
        $display("address filter done");
        xfer(7'h53, 8'h40, 0, 8'h00);
        takes = 16'h0000;
        mst.start();
        mst.sendByte({7'h53, 1'b1}, ak);
        mst.recvByte(1'b1, b);
        chk(b, 8'h70);
        mst.recvByte(1'b0, b);
        mst.stop();
        chk({ak, b}, 9'h171);
        chk(takes, 16'h0002);
        // Pointer write, then a repeated start straight into the read
        takes = 16'h0000;
        mst.start();
        mst.sendByte({7'h53, 1'b0}, ak);
        mst.sendByte(8'h40, ak);
        mst.start();
        mst.sendByte({7'h53, 1'b1}, ak);
        mst.recvByte(1'b0, b);
        mst.stop();
        chk({ak, b}, 9'h170);
        chk(takes, 16'h0001);
        $display("read done");
        // Stall with the device driving a zero until it gives up
        mst.start();
        mst.sendByte({7'h53, 1'b1}, ak);
        repeat (TMO + 50) @(posedge sys_clk);
        chk(sdaOe_n_q, 1'b1);
        mst.recvByte(1'b0, b);
        chk(b, 8'hFF);
        mst.stop();
        xfer(7'h53, 8'h00, 0, 8'h00);
        chk(ak, 1'b1);
        $display("bus timeout done");
        summarize();
    end
endmodule // tb_top
`default_nettype wire
